// ===== verilog/dmas_pkg.sv
// constants, register map and enumerations shared by the slice files
// assumes a single 200 MHz system clock; no timing figures are needed by the datapath
package dmas_pkg;
    // register byte offsets on the 32-bit bus
    localparam logic [11:0] CFG_OFS = 12'h000;
    localparam logic [11:0] SEL_OFS = 12'h004;
    localparam logic [11:0] RND_OFS = 12'h008;
    localparam logic [11:0] MASK_LO_OFS = 12'h00c;
    localparam logic [11:0] MASK_HI_OFS = 12'h010;
    localparam logic [11:0] PAT_LO_OFS = 12'h014;
    localparam logic [11:0] PAT_HI_OFS = 12'h018;
    localparam logic [11:0] FLAG_OFS = 12'h01c;
    localparam logic [11:0] RES_LO_OFS = 12'h020;
    localparam logic [11:0] RES_HI_OFS = 12'h024;

    // configuration word fields
    localparam int CFG_MODE_LSB = 0;
    localparam int CFG_IN_EN_BIT = 3;
    localparam int CFG_PIPE_EN_BIT = 4;
    localparam int CFG_OUT_EN_BIT = 5;
    localparam int CFG_AS_DYN_BIT = 6;
    localparam int CFG_AS_SUB_BIT = 7;
    localparam int CFG_SH_DYN_BIT = 8;
    localparam int CFG_SH_SER_BIT = 9;
    localparam int CFG_CSEL_LSB = 10;
    localparam int CFG_ASYNC_BIT = 12;

    // select word: two bits per stage, stage index times two above each base
    localparam int SEL_CLK_LSB = 0;
    localparam int SEL_CE_LSB = 8;
    localparam int SEL_RST_LSB = 16;
    localparam int STG_IN = 0;
    localparam int STG_PIPE = 1;
    localparam int STG_OUT = 2;
    localparam int STG_N = 3;

    // rounding word fields
    localparam int RND_METH_LSB = 0;
    localparam int RND_POS_LSB = 8;

    // status word bit positions
    localparam int FLG_ZERO_BIT = 0;
    localparam int FLG_MZERO_BIT = 1;
    localparam int FLG_MONES_BIT = 2;
    localparam int FLG_PAT_BIT = 3;
    localparam int FLG_PATINV_BIT = 4;
    localparam int FLG_OVER_BIT = 5;
    localparam int FLG_UNDER_BIT = 6;
    localparam int FLG_EITHER_BIT = 7;

    // values after reset: all three register stages enabled, product-only mode
    localparam logic [31:0] CFG_RST = 32'h0000_0038;
    localparam logic [31:0] SEL_RST = 32'h0000_0000;
    localparam logic [31:0] RND_RST = 32'h0000_0000;
    localparam logic [15:0] LFSR_SEED = 16'hace1;

    typedef enum logic [2:0] {
        MODE_PRODUCT_ONLY,
        MODE_PRODUCT_ACCUM,
        MODE_TWO_PRODUCT_ACCUM,
        MODE_TWO_PRODUCT_ADD_SUB,
        MODE_FOUR_PRODUCT_SUM,
        MODE_ADDER_ONLY
    } dmas_mode_t;

    typedef enum logic [2:0] {
        RND_NONE,
        RND_TOWARD_ZERO,
        RND_TOWARD_INF,
        RND_DYNAMIC,
        RND_RANDOM,
        RND_CONVERGENT
    } dmas_round_t;

    typedef enum logic [1:0] {
        CSEL_ZERO,
        CSEL_C_OPERAND,
        CSEL_CASCADE
    } dmas_csel_t;
endpackage : dmas_pkg

// ===== verilog/dmas_stage.sv
// one optional register stage of the slice with its own tick, enable and reset
// assumes tick, enable and reset selects are already resolved on the system clock
`timescale 1ns/1ps
module dmas_stage #(
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic reg_en,
    input wire logic tick,
    input wire logic lce,
    input wire logic lrst,
    input wire logic async_rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q,
    output logic [W-1:0] q_reg
);
    logic [W-1:0] q_q;

    // the sync reset waits for the stage's own tick; the other choice acts on the next edge
    always_ff @(posedge clk) begin
        if (rst) begin
            q_q <= '0;
        end else if (ce) begin
            if (lrst && (async_rst || tick)) begin
                q_q <= '0;
            end else if (tick && lce) begin
                q_q <= d;
            end
        end
    end

    assign q = reg_en ? q_q : d;
    assign q_reg = q_q;
endmodule : dmas_stage

// ===== verilog/dmas_round_flags.sv
// rounding by offset add (constant, dyn_up or random bits) and truncation, plus the comparison flags of the result
// purely combinational; the caller registers everything it drives out
`timescale 1ns/1ps
module dmas_round_flags #(
    parameter int W = 54
) (
    input wire logic [W-1:0] value,
    input wire logic bypass,
    input wire logic [2:0] method,
    input wire logic [5:0] pos,
    input wire logic dyn_up,
    input wire logic [W-1:0] rnd_bits,
    input wire logic [W-1:0] mask,
    input wire logic [W-1:0] pattern,
    output logic [W-1:0] result,
    output logic [4:0] flags
);
    logic [W-1:0] low_ones;
    logic [W-1:0] half;
    logic [W-1:0] addend;
    logic [W-1:0] sum;

    always_comb begin
        low_ones = (W'(1) << pos) - W'(1);
        half = (pos == 6'h00) ? '0 : (W'(1) << (pos - 6'h01));
        case (dmas_pkg::dmas_round_t'(method))
            dmas_pkg::RND_TOWARD_ZERO: addend = value[W-1] ? low_ones : '0;
            dmas_pkg::RND_TOWARD_INF: addend = value[W-1] ? (half - W'(1)) : half;
            dmas_pkg::RND_DYNAMIC: addend = dyn_up ? half : '0;
            dmas_pkg::RND_RANDOM: addend = rnd_bits & low_ones;
            dmas_pkg::RND_CONVERGENT: addend = (half == '0) ? '0 : (half - W'(1) + W'(value[pos]));
            default: addend = '0;
        endcase
        sum = value + addend;
        if (bypass || pos == 6'h00 || method == 3'h0) begin
            result = value;
        end else begin
            result = sum & ~low_ones;
        end
        // a mask bit set to one excludes that bit from the masked compares; the zero flag ignores the mask
        flags[0] = (result == '0);
        flags[1] = ((result & ~mask) == '0);
        flags[2] = ((result | mask) == '1);
        flags[3] = (((result ^ pattern) & ~mask) == '0);
        flags[4] = (((result ^ ~pattern) & ~mask) == '0);
    end
endmodule : dmas_round_flags

// ===== verilog/dmas_slice.sv
// multiply-accumulate slice: operand stage, product stage, ALU and output register
// assumes fabric inputs are on CLK; tick, enable and reset sources are fabric strobes on CLK
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module dmas_slice #(
    parameter int A_W = 18,
    parameter int ACC_W = 54
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [A_W-1:0] OPERAND_A_FIRST,
    input wire logic [A_W-1:0] OPERAND_A_SECOND,
    input wire logic [A_W-1:0] OPERAND_B_FIRST,
    input wire logic [A_W-1:0] OPERAND_B_SECOND,
    input wire logic [A_W-1:0] SHIFT_A_IN,
    input wire logic [A_W-1:0] SHIFT_B_IN,
    input wire logic SHIFT_LOAD,
    input wire logic ADD_SUB,
    input wire logic LOAD_INIT,
    input wire logic [ACC_W-1:0] INIT_VALUE,
    input wire logic [ACC_W-1:0] C_OPERAND,
    input wire logic [ACC_W-1:0] CASCADE_IN,
    input wire logic ROUND_UP,
    input wire logic [3:0] CLOCK_SOURCE,
    input wire logic [3:0] ENABLE_SOURCE,
    input wire logic [3:0] RESET_SOURCE,
    output logic [ACC_W-1:0] RESULT,
    output logic [ACC_W-1:0] CASCADE_OUT,
    output logic [A_W-1:0] SHIFT_A_OUT,
    output logic [A_W-1:0] SHIFT_B_OUT,
    output logic ZERO_RESULT_FLAG,
    output logic MASKED_ZERO_FLAG,
    output logic MASKED_ONES_FLAG,
    output logic MASKED_PATTERN_MATCH_FLAG,
    output logic MASKED_INVERSE_PATTERN_FLAG,
    output logic ACCUM_OVER_FLAG,
    output logic ACCUM_UNDER_FLAG,
    output logic ACCUM_WRAP_EITHER_FLAG
);
    localparam int P_W = 2 * A_W;
    localparam int ADD_W = 3 * A_W;
    localparam int EW = ACC_W + 1;
    localparam int IN_W = 4 * A_W + 1;
    localparam int PIPE_W = 2 * P_W + ADD_W + 1;

    // the hi register words and the 6-bit rounding position need these bounds
    if (3 * A_W > ACC_W || ACC_W <= 32 || ACC_W > 64 || A_W < 2) begin : g_bad_width
        $error("dmas_slice: need 3*A_W <= ACC_W and 32 < ACC_W <= 64");
    end

    logic [31:0] cfg_q;
    logic [31:0] sel_q;
    logic [31:0] rnd_q;
    logic [ACC_W-1:0] mask_q;
    logic [ACC_W-1:0] pat_q;
    logic [15:0] lfsr_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [ACC_W-1:0] res_q;
    logic [4:0] cmp_q;
    logic over_q;
    logic under_q;
    logic either_q;

    dmas_pkg::dmas_mode_t mode;
    dmas_pkg::dmas_csel_t csel;
    logic acc_mode;
    logic [dmas_pkg::STG_N-1:0] stg_tick;
    logic [dmas_pkg::STG_N-1:0] stg_ce;
    logic [dmas_pkg::STG_N-1:0] stg_rst;
    logic async_sel;

    assign mode = dmas_pkg::dmas_mode_t'(cfg_q[dmas_pkg::CFG_MODE_LSB +: 3]);
    assign csel = dmas_pkg::dmas_csel_t'(cfg_q[dmas_pkg::CFG_CSEL_LSB +: 2]);
    assign acc_mode = (mode == dmas_pkg::MODE_PRODUCT_ACCUM) || (mode == dmas_pkg::MODE_TWO_PRODUCT_ACCUM);
    assign async_sel = cfg_q[dmas_pkg::CFG_ASYNC_BIT];

    for (genvar s = 0; s < dmas_pkg::STG_N; s++) begin : g_sel
        assign stg_tick[s] = CLOCK_SOURCE[sel_q[dmas_pkg::SEL_CLK_LSB + 2 * s +: 2]];
        assign stg_ce[s] = ENABLE_SOURCE[sel_q[dmas_pkg::SEL_CE_LSB + 2 * s +: 2]];
        assign stg_rst[s] = RESET_SOURCE[sel_q[dmas_pkg::SEL_RST_LSB + 2 * s +: 2]];
    end

    // operand stage
    logic serial_ld;
    logic sub_in;
    logic [IN_W-1:0] in_d;
    logic [IN_W-1:0] in_q;
    logic [IN_W-1:0] in_reg;
    logic [A_W-1:0] ia1;
    logic [A_W-1:0] ia2;
    logic [A_W-1:0] ib1;
    logic [A_W-1:0] ib2;
    logic isub;

    assign serial_ld = cfg_q[dmas_pkg::CFG_SH_DYN_BIT] ? SHIFT_LOAD : cfg_q[dmas_pkg::CFG_SH_SER_BIT];
    assign sub_in = cfg_q[dmas_pkg::CFG_AS_DYN_BIT] ? ADD_SUB : cfg_q[dmas_pkg::CFG_AS_SUB_BIT];
    assign in_d = {sub_in, OPERAND_B_SECOND, serial_ld ? SHIFT_B_IN : OPERAND_B_FIRST,
                   OPERAND_A_SECOND, serial_ld ? SHIFT_A_IN : OPERAND_A_FIRST};

    dmas_stage #(.W(IN_W)) u_in_stage (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .reg_en(cfg_q[dmas_pkg::CFG_IN_EN_BIT]),
        .tick(stg_tick[dmas_pkg::STG_IN]),
        .lce(stg_ce[dmas_pkg::STG_IN]),
        .lrst(stg_rst[dmas_pkg::STG_IN]),
        .async_rst(async_sel),
        .d(in_d),
        .q(in_q),
        .q_reg(in_reg)
    );

    assign {isub, ib2, ib1, ia2, ia1} = in_q;

    // product stage; the adder-only operand is the three operands side by side
    logic [P_W-1:0] prod0;
    logic [P_W-1:0] prod1;
    logic [PIPE_W-1:0] pipe_q;
    logic [P_W-1:0] pp0;
    logic [P_W-1:0] pp1;
    logic [ADD_W-1:0] padd;
    logic psub;

    assign prod0 = $signed({{A_W{ia1[A_W-1]}}, ia1}) * $signed({{A_W{ia2[A_W-1]}}, ia2});
    assign prod1 = $signed({{A_W{ib1[A_W-1]}}, ib1}) * $signed({{A_W{ib2[A_W-1]}}, ib2});

    dmas_stage #(.W(PIPE_W)) u_pipe_stage (
        .clk(CLK),
        .rst(RST),
        .ce(CE),
        .reg_en(cfg_q[dmas_pkg::CFG_PIPE_EN_BIT]),
        .tick(stg_tick[dmas_pkg::STG_PIPE]),
        .lce(stg_ce[dmas_pkg::STG_PIPE]),
        .lrst(stg_rst[dmas_pkg::STG_PIPE]),
        .async_rst(async_sel),
        .d({isub, ia1, ia2, ib1, prod1, prod0}),
        .q(pipe_q),
        .q_reg()
    );

    assign {psub, padd, pp1, pp0} = pipe_q;

    // ALU, one bit wider than the accumulator so a wrap can be seen
    logic signed [EW-1:0] e0;
    logic signed [EW-1:0] e1;
    logic signed [EW-1:0] eadd;
    logic signed [EW-1:0] ecm;
    logic signed [EW-1:0] eacc;
    logic signed [EW-1:0] pair;
    logic signed [EW-1:0] alu_sum;
    logic alu_over;
    logic alu_under;

    always_comb begin
        e0 = EW'($signed(pp0));
        e1 = EW'($signed(pp1));
        eadd = EW'($signed(padd));
        eacc = EW'($signed(res_q));
        case (csel)
            dmas_pkg::CSEL_C_OPERAND: ecm = EW'($signed(C_OPERAND));
            dmas_pkg::CSEL_CASCADE: ecm = EW'($signed(CASCADE_IN));
            default: ecm = '0;
        endcase
        pair = psub ? (e0 - e1) : (e0 + e1);
        case (mode)
            dmas_pkg::MODE_PRODUCT_ONLY: alu_sum = e0;
            dmas_pkg::MODE_PRODUCT_ACCUM: alu_sum = psub ? (eacc - e0) : (eacc + e0);
            dmas_pkg::MODE_TWO_PRODUCT_ACCUM: alu_sum = psub ? (eacc - e0 - e1) : (eacc + e0 + e1);
            dmas_pkg::MODE_TWO_PRODUCT_ADD_SUB: alu_sum = pair;
            dmas_pkg::MODE_FOUR_PRODUCT_SUM: alu_sum = pair + ecm;
            dmas_pkg::MODE_ADDER_ONLY: alu_sum = psub ? (ecm - eadd) : (ecm + eadd);
            default: alu_sum = '0;
        endcase
        // top two bits disagree only when the ACC_W-bit result wrapped
        alu_over = (alu_sum[EW-1:EW-2] == 2'b01);
        alu_under = (alu_sum[EW-1:EW-2] == 2'b10);
    end

    // rounding is kept out of the running sum so the accumulator never loses precision
    logic [ACC_W-1:0] next_res;
    logic [4:0] next_cmp;
    logic [63:0] rnd_rep;

    assign rnd_rep = {4{lfsr_q}};

    dmas_round_flags #(.W(ACC_W)) u_round (
        .value(alu_sum[ACC_W-1:0]),
        .bypass(acc_mode),
        .method(rnd_q[dmas_pkg::RND_METH_LSB +: 3]),
        .pos(rnd_q[dmas_pkg::RND_POS_LSB +: 6]),
        .dyn_up(ROUND_UP),
        .rnd_bits(rnd_rep[ACC_W-1:0]),
        .mask(mask_q),
        .pattern(pat_q),
        .result(next_res),
        .flags(next_cmp)
    );

    always_ff @(posedge CLK) begin
        if (RST) begin
            lfsr_q <= dmas_pkg::LFSR_SEED;
        end else if (CE) begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        end
    end

    // output register; a bypassed output reloads on every cycle instead of on its tick
    logic out_en;
    logic out_load;
    logic out_clr;

    assign out_en = acc_mode || cfg_q[dmas_pkg::CFG_OUT_EN_BIT];
    assign out_load = out_en ? (stg_tick[dmas_pkg::STG_OUT] && stg_ce[dmas_pkg::STG_OUT]) : 1'b1;
    assign out_clr = out_en && stg_rst[dmas_pkg::STG_OUT] && (async_sel || stg_tick[dmas_pkg::STG_OUT]);

    always_ff @(posedge CLK) begin
        if (RST) begin
            res_q <= '0;
        end else if (CE) begin
            if (out_clr) begin
                res_q <= '0;
            end else if (out_load && acc_mode && LOAD_INIT) begin
                res_q <= INIT_VALUE;
            end else if (out_load) begin
                res_q <= next_res;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cmp_q <= '0;
            over_q <= 1'b0;
            under_q <= 1'b0;
            either_q <= 1'b0;
        end else if (CE) begin
            if (out_clr) begin
                cmp_q <= '0;
                over_q <= 1'b0;
                under_q <= 1'b0;
                either_q <= 1'b0;
            end else if (out_load && acc_mode && LOAD_INIT) begin
                cmp_q <= '0;
                over_q <= 1'b0;
                under_q <= 1'b0;
                either_q <= 1'b0;
            end else if (out_load) begin
                cmp_q <= next_cmp;
                over_q <= alu_over;
                under_q <= alu_under;
                either_q <= alu_over || alu_under;
            end
        end
    end

    // register bus: one wait state, answer and data both leave flops
    logic apb_access;
    logic apb_done;
    logic [31:0] rd_mux;
    logic rd_hit;

    assign apb_access = PSEL && PENABLE;
    assign apb_done = apb_access && pready_q;

    always_comb begin
        rd_hit = 1'b1;
        case (PADDR)
            dmas_pkg::CFG_OFS: rd_mux = cfg_q;
            dmas_pkg::SEL_OFS: rd_mux = sel_q;
            dmas_pkg::RND_OFS: rd_mux = rnd_q;
            dmas_pkg::MASK_LO_OFS: rd_mux = mask_q[31:0];
            dmas_pkg::MASK_HI_OFS: rd_mux = 32'(mask_q[ACC_W-1:32]);
            dmas_pkg::PAT_LO_OFS: rd_mux = pat_q[31:0];
            dmas_pkg::PAT_HI_OFS: rd_mux = 32'(pat_q[ACC_W-1:32]);
            dmas_pkg::FLAG_OFS: rd_mux = {24'h00_0000, either_q, under_q, over_q, cmp_q};
            dmas_pkg::RES_LO_OFS: rd_mux = res_q[31:0];
            dmas_pkg::RES_HI_OFS: rd_mux = 32'(res_q[ACC_W-1:32]);
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (CE) begin
            pready_q <= apb_access && !pready_q;
            if (apb_access && !pready_q) begin
                pslverr_q <= !rd_hit;
                prdata_q <= PWRITE ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    // writes to the read-only words are dropped without an error
    always_ff @(posedge CLK) begin
        if (RST) begin
            cfg_q <= dmas_pkg::CFG_RST;
            sel_q <= dmas_pkg::SEL_RST;
            rnd_q <= dmas_pkg::RND_RST;
            mask_q <= '0;
            pat_q <= '0;
        end else if (CE && apb_done && PWRITE) begin
            case (PADDR)
                dmas_pkg::CFG_OFS: cfg_q <= PWDATA;
                dmas_pkg::SEL_OFS: sel_q <= PWDATA;
                dmas_pkg::RND_OFS: rnd_q <= PWDATA;
                dmas_pkg::MASK_LO_OFS: mask_q[31:0] <= PWDATA;
                dmas_pkg::MASK_HI_OFS: mask_q[ACC_W-1:32] <= PWDATA[ACC_W-33:0];
                dmas_pkg::PAT_LO_OFS: pat_q[31:0] <= PWDATA;
                dmas_pkg::PAT_HI_OFS: pat_q[ACC_W-1:32] <= PWDATA[ACC_W-33:0];
                default: ;
            endcase
        end
    end

    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PRDATA = prdata_q;
    assign RESULT = res_q;
    assign CASCADE_OUT = res_q;
    assign SHIFT_A_OUT = in_reg[A_W-1:0];
    assign SHIFT_B_OUT = in_reg[3*A_W-1:2*A_W];
    assign ZERO_RESULT_FLAG = cmp_q[dmas_pkg::FLG_ZERO_BIT];
    assign MASKED_ZERO_FLAG = cmp_q[dmas_pkg::FLG_MZERO_BIT];
    assign MASKED_ONES_FLAG = cmp_q[dmas_pkg::FLG_MONES_BIT];
    assign MASKED_PATTERN_MATCH_FLAG = cmp_q[dmas_pkg::FLG_PAT_BIT];
    assign MASKED_INVERSE_PATTERN_FLAG = cmp_q[dmas_pkg::FLG_PATINV_BIT];
    assign ACCUM_OVER_FLAG = over_q;
    assign ACCUM_UNDER_FLAG = under_q;
    assign ACCUM_WRAP_EITHER_FLAG = either_q;
endmodule : dmas_slice

// ===== verification/dmas_slice_props.sv
// checker on the slice ports: wrap flags, cascade copy, reset, bus handshake, clock enable
// assumes binding to dmas_slice with CE held high across every bus transfer
`timescale 1ns/1ps
module dmas_slice_props #(
    parameter int ACC_W = 54
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic [ACC_W-1:0] RESULT,
    input wire logic [ACC_W-1:0] CASCADE_OUT,
    input wire logic ACCUM_OVER_FLAG,
    input wire logic ACCUM_UNDER_FLAG,
    input wire logic ACCUM_WRAP_EITHER_FLAG
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);
    sequence s_setup;
        PSEL && !PENABLE && CE;
    endsequence
    sequence s_access;
        PSEL && PENABLE && CE;
    endsequence
    a_either_flag: assert property (ACCUM_WRAP_EITHER_FLAG == (ACCUM_OVER_FLAG || ACCUM_UNDER_FLAG))
        else $error("either flag wrong");
    a_wrap_apart: assert property (!(ACCUM_OVER_FLAG && ACCUM_UNDER_FLAG))
        else $error("over and under together");
    a_cascade_copy: assert property (CASCADE_OUT == RESULT)
        else $error("cascade out differs from result");
    a_reset_clear: assert property (disable iff (1'b0) RST && CE |=>
        RESULT == '0 && !ACCUM_WRAP_EITHER_FLAG && !PREADY) else $error("reset left state");
    a_ready_wait: assert property (s_setup ##1 s_access |=> PREADY)
        else $error("ready not in second access cycle");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("ready held");
    a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
        else $error("ready outside access");
    a_ce_freeze: assert property (!CE |=> $stable(RESULT) && $stable(ACCUM_WRAP_EITHER_FLAG))
        else $error("outputs moved without enable");
endmodule : dmas_slice_props

// ===== verification/dmas_fabric_model.sv
// fabric model: random operands, add/sub and accumulator loads, plus enables and ticks
// assumes the bench seeded $urandom; idle (run low) it stalls the output stage but keeps CE on
`timescale 1ns/1ps
module dmas_fabric_model (
    input wire logic clk,
    input wire logic run,
    output logic [17:0] a1 = 18'h0,
    output logic [17:0] a2 = 18'h0,
    output logic [17:0] b1 = 18'h0,
    output logic [17:0] b2 = 18'h0,
    output logic ads = 1'b0,
    output logic ld = 1'b0,
    output logic [53:0] init = 54'h0,
    output logic ce = 1'b1,
    output logic [3:0] tk = 4'hf,
    output logic [3:0] en = 4'h0
);
    // one operand in eight is zero so that zero results turn up
    function automatic logic [17:0] op();
        return ($urandom % 8 == 0) ? 18'h0 : 18'($urandom);
    endfunction : op
    always @(posedge clk) begin
        a1 <= op();
        a2 <= op();
        b1 <= op();
        b2 <= op();
        ads <= 1'($urandom);
        // request and value change only after an edge, so both stand at the loading edge
        ld <= run && $urandom % 16 == 0;
        init <= $urandom % 2 == 0 ? 54'h1f_ffff_ffff_ffff : {1'b1, 53'($urandom)};
        ce <= !run || $urandom % 8 != 0;
        tk <= {3'($urandom), !run || $urandom % 8 != 0};
        en <= {3'($urandom), run && $urandom % 8 != 0};
    end
endmodule : dmas_fabric_model

// ===== verification/dsp_multiply_accumulate_slice_tb.sv
// bench: bus map checks, then every datapath mode under random fabric traffic
// assumes in and pipe stages bypassed, so the output stage on source 0 loads one edge after operands
`timescale 1ns/1ps
module dsp_multiply_accumulate_slice_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic run = 1'b0;
    logic live = 1'b0;
    logic [2:0] md = 3'h0;
    logic [53:0] c = 54'h0;
    logic [53:0] cas = 54'h0;
    logic [53:0] exp_q = 54'h0;
    logic [1:0] ouf_q = 2'h0;
    logic [35:0] sh_q = 36'h0;
    logic [3:0] rs = 4'h0;
    logic clr_q = 1'b0;
    logic [17:0] a1, a2, b1, b2;
    logic ads, ld, ce, pready, pslverr, err;
    logic [3:0] tk, en;
    logic [53:0] init, res, cascade_out;
    logic [31:0] prdata, rd, cfg;
    logic signed [54:0] p1, p2, s;
    wire [7:0] fl;
    wire [35:0] sh;
    int num_errors = 0;
    int n_tests = 0;

    always #2.5 clk = ~clk;

    dmas_fabric_model u_src (.clk(clk), .run(run), .a1(a1), .a2(a2), .b1(b1), .b2(b2), .ads(ads), .ld(ld),
        .init(init), .ce(ce), .tk(tk), .en(en));
    dmas_slice u_dut (.CLK(clk), .RST(rst), .CE(ce), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .OPERAND_A_FIRST(a1), .OPERAND_A_SECOND(a2), .OPERAND_B_FIRST(b1), .OPERAND_B_SECOND(b2),
        .SHIFT_A_IN(18'h0), .SHIFT_B_IN(18'h0), .SHIFT_LOAD(1'b0), .ADD_SUB(ads), .LOAD_INIT(ld),
        .INIT_VALUE(init), .C_OPERAND(c), .CASCADE_IN(cas), .ROUND_UP(1'b0), .CLOCK_SOURCE(tk),
        .ENABLE_SOURCE(en), .RESET_SOURCE(rs), .RESULT(res), .CASCADE_OUT(cascade_out), .SHIFT_A_OUT(sh[17:0]),
        .SHIFT_B_OUT(sh[35:18]), .ZERO_RESULT_FLAG(fl[0]), .MASKED_ZERO_FLAG(fl[1]), .MASKED_ONES_FLAG(fl[2]),
        .MASKED_PATTERN_MATCH_FLAG(fl[3]), .MASKED_INVERSE_PATTERN_FLAG(fl[4]), .ACCUM_OVER_FLAG(fl[5]),
        .ACCUM_UNDER_FLAG(fl[6]), .ACCUM_WRAP_EITHER_FLAG(fl[7]));

    always @(posedge clk) begin
        c <= {22'($urandom), $urandom};
        cas <= {22'($urandom), $urandom};
        rs <= {3'($urandom), $urandom % 32 == 0};
    end

    // reference of the output register; mask and pattern stay zero
    always @(posedge clk) begin
        live <= run && (live || (ce && tk[0] && en[0]));
        if (rst) begin
            exp_q <= 54'h0;
            ouf_q <= 2'h0;
            sh_q <= 36'h0;
        end else if (ce && rs[0] && tk[0]) begin
            exp_q <= 54'h0;
            ouf_q <= 2'h0;
            sh_q <= 36'h0;
            clr_q <= 1'b1;
        end else if (ce && tk[0] && en[0]) begin
            clr_q <= 1'b0;
            sh_q <= {b1, a1};
            p1 = $signed(a1) * $signed(a2);
            p2 = $signed(b1) * $signed(b2);
            p2 = (cfg[6] && ads) ? -p2 : p2;
            case (md)
                3'h0: s = p1;
                3'h1: s = $signed({exp_q[53], exp_q}) + p1;
                3'h2: s = $signed({exp_q[53], exp_q}) + p1 + p2;
                3'h3: s = p1 + p2;
                3'h4: s = p1 + p2 + $signed({cas[53], cas});
                default: s = (cfg[6] && ads) ? c - {1'b0, a1, a2, b1} : {1'b0, a1, a2, b1} + c;
            endcase
            if (ld && (md == 3'h1 || md == 3'h2)) begin
                exp_q <= init;
                ouf_q <= 2'h0;
            end else begin
                exp_q <= s[53:0];
                ouf_q <= {s[54:53] == 2'b01, s[54:53] == 2'b10};
            end
        end
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] want);
        n_tests++;
        if (got !== want) begin
            num_errors++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, want);
        end
    endtask : chk

    always @(negedge clk) begin
        if (live) begin
            chk(res, exp_q);
            chk(cascade_out, exp_q);
            chk(sh, sh_q);
            if (md == 3'h1 || md == 3'h2)
                chk(fl[7:5], {|ouf_q, ouf_q[0], ouf_q[1]});
            else
                chk(fl[4:0], clr_q ? 5'h0 : {&exp_q, ~|exp_q, &exp_q, ~|exp_q, ~|exp_q});
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task automatic complete_run();
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        complete_run();
    end

    initial begin
        void'($urandom(65908));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b0, dmas_pkg::CFG_OFS, 32'h0);
        chk(rd, dmas_pkg::CFG_RST);
        apb(1'b0, 12'h040, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int m = 0; m < 6; m++) begin
            md = 3'(m);
            cfg = 32'h20 | 32'(m) | (m > 2 ? 32'h40 : 32'h0) | (m == 4 ? 32'h800 : m == 5 ? 32'h400 : 32'h0);
            apb(1'b1, dmas_pkg::CFG_OFS, cfg);
            apb(1'b0, dmas_pkg::CFG_OFS, 32'h0);
            chk(rd, cfg);
            run <= 1'b1;
            repeat (200) @(posedge clk);
            run <= 1'b0;
            repeat (3) @(posedge clk);
            apb(1'b0, dmas_pkg::RES_LO_OFS, 32'h0);
            chk(rd, exp_q[31:0]);
            apb(1'b0, dmas_pkg::RES_HI_OFS, 32'h0);
            chk(rd, {10'h0, exp_q[53:32]});
        end
        complete_run();
    end
endmodule : dsp_multiply_accumulate_slice_tb

bind dmas_slice dmas_slice_props #(.ACC_W(ACC_W)) u_props (.CLK(CLK), .RST(RST), .CE(CE), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .RESULT(RESULT), .CASCADE_OUT(CASCADE_OUT),
    .ACCUM_OVER_FLAG(ACCUM_OVER_FLAG), .ACCUM_UNDER_FLAG(ACCUM_UNDER_FLAG),
    .ACCUM_WRAP_EITHER_FLAG(ACCUM_WRAP_EITHER_FLAG));
